// ==== bench/status_host.sv ====
// host model: issues status requests, keeps the last delivered response
// assumes the guard answers resp_req one cycle later
`timescale 1ns/1ns
module status_host (
  // clock
  input  wire logic                    aclk,
  // bench requests
  input  wire logic                    ask,
  input  wire logic                    ask_long,
  // guard side
  output logic                         resp_req,
  output logic                         resp_long,
  input  wire logic                    resp_valid,
  input  wire guard_pkg::status_resp_t status_resp,
  output guard_pkg::status_resp_t      got
);
  assign resp_req  = ask;
  assign resp_long = ask_long;
  // execution bits only show in a later response, so keep the last one
  always_ff @(posedge aclk) begin
    if (resp_valid) got <= status_resp;
  end
endmodule

// ==== bench/tb.sv ====
// bench for the card status guard
// assumes the host model forms the status requests
`timescale 1ns/1ns
module tb;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, ask = 0, ask_long = 0, reg_sel_req = 0;
  logic awready, wready, bvalid, arready, rvalid, resp_req, resp_long;
  logic resp_valid, reg_sel_valid, reg_sel_ok, legacy_write_block;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, nvme_capacity, d;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, r, sv;
  logic [2:0] reg_sel = 0;
  logic [23:0] class_code;
  guard_pkg::card_event_t card_event = '0;
  guard_pkg::nvme_cmd_t nvme_cmd = '0;
  guard_pkg::verdict_t verdict, v;
  guard_pkg::status_resp_t status_resp, got;
  int err_total = 0, num_checks = 0, n;
  always #5 aclk = ~aclk;
  card_status_guard DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .card_event,
    .resp_req, .resp_long, .status_resp, .resp_valid, .reg_sel_req,
    .reg_sel, .reg_sel_valid, .reg_sel_ok, .nvme_cmd, .verdict,
    .legacy_write_block, .class_code, .nvme_capacity);
  status_host HOST (.aclk, .ask, .ask_long, .resp_req, .resp_long,
    .resp_valid, .status_resp, .got);
  //////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge aclk);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    @(posedge aclk);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    for (n = 0; n < 50 && bvalid !== 1'h1; n++) @(negedge aclk);
    if (n == 50) begin
      err_total++;
      conclude;
    end
    @(posedge aclk);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    @(posedge aclk);
    arvalid <= 1'h0;
    for (n = 0; n < 50 && rvalid !== 1'h1; n++) @(negedge aclk);
    if (n == 50) begin
      err_total++;
      conclude;
    end
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'h0;
  endtask
  // one cycle of card event, status request, nvme command and selector
  task automatic st(input guard_pkg::card_event_t e, input logic q, l,
                    input guard_pkg::nvme_cmd_t c);
    @(posedge aclk);
    card_event <= e;
    ask <= q;
    ask_long <= l;
    nvme_cmd <= c;
    reg_sel_req <= 1'h1;
    @(posedge aclk);
    card_event <= '0;
    ask <= 1'h0;
    ask_long <= 1'h0;
    nvme_cmd <= '0;
    reg_sel_req <= 1'h0;
    @(negedge aclk);
    v = verdict;
    sv = {reg_sel_valid, reg_sel_ok};
    @(negedge aclk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    rd(guard_pkg::OFF_CLASS);
    chk("class", 32'h0001_0802, d);
    rd(8'h40);
    chk("unmapped", guard_pkg::RESP_SLVERR, r);
    wr(8'h40, 32'h0000_0000);
    chk("wr unmapped", guard_pkg::RESP_SLVERR, bresp);
    st('0, 1'h1, 1'h0, '0);
    chk("idle", 8'h01, got.short_byte);
    st(7'h01, 1'h0, 1'h0, '0);
    st('0, 1'h1, 1'h0, '0);
    chk("ready", 8'h00, got.short_byte);
    st(7'h02, 1'h0, 1'h0, '0);
    st('0, 1'h1, 1'h0, '0);
    chk("idle again", 8'h01, got.short_byte);
    for (int i = 3; i < 7; i++) begin
      st(7'h01 << i, 1'h0, 1'h0, '0);
      st('0, 1'h1, 1'h1, '0);
      chk("error bit", (i > 4) ? 8'h80 : 8'h02, got.long_byte);
      st('0, 1'h1, 1'h1, '0);
      chk("cleared", 8'h00, got.long_byte);
    end
    st(7'h08, 1'h1, 1'h1, '0);
    st('0, 1'h1, 1'h1, '0);
    chk("set wins", 8'h02, got.long_byte);
    st(7'h04, 1'h1, 1'h0, '0);
    chk("erase reset", 8'h03, got.short_byte);
    wr(guard_pkg::OFF_PROTECT, 32'h1);
    st('0, 1'h1, 1'h1, 6'h38);
    chk("locked", 8'h01, got.long_byte);
    chk("admin deny", 10'h301, v);
    st('0, 1'h0, 1'h0, 6'h24);
    chk("io deny", 10'h302, v);
    wr(guard_pkg::OFF_PROTECT, 32'h2);
    st('0, 1'h1, 1'h1, 6'h28);
    chk("unlocked", 8'h00, got.long_byte);
    chk("read ok", 10'h200, v);
    st('0, 1'h0, 1'h0, 6'h24);
    chk("wp write", 10'h302, v);
    chk("wp shared", 1'h1, legacy_write_block);
    st('0, 1'h0, 1'h0, 6'h2a);
    chk("area deny", 2'h3, v[9:8]);
    wr(guard_pkg::OFF_CTRL, 32'h1);
    reg_sel <= guard_pkg::SEL_RCA;
    st('0, 1'h0, 1'h0, '0);
    chk("address reg", 2'h2, sv);
    reg_sel <= 3'h1;
    st('0, 1'h0, 1'h0, '0);
    chk("other reg", 2'h3, sv);
    wr(guard_pkg::OFF_CTRL, 32'h2);
    wr(guard_pkg::OFF_PROTECT, 32'h4);
    rd(guard_pkg::OFF_PROTECT);
    chk("pwp no auth", 32'h0, d);
    wr(guard_pkg::OFF_CTRL, 32'he);
    wr(guard_pkg::OFF_PROTECT, 32'hc);
    rd(guard_pkg::OFF_PROTECT);
    chk("pwp auth", 32'hc, d);
    wr(guard_pkg::OFF_PROTECT, 32'h8);
    st('0, 1'h1, 1'h1, 6'h24);
    chk("pwp reverse", 8'h80, got.long_byte);
    chk("pwp write", 10'h302, v);
    wr(guard_pkg::OFF_USER_SIZE, 32'h0012_3400);
    @(negedge aclk);
    chk("capacity", 32'h0012_3400, nvme_capacity);
    conclude;
  end
endmodule

// ==== design/card_status_guard.sv ====
// card status bits, shared protection state and nvme command guard
// assumes all card-side strobes are single-cycle pulses on aclk
//
// Summary of operation
// - overwrite error on mismatch or reverse; read clears
// - erase skip set on partial erase; read clears
// - lock failed set on sequence/password error
// - locked bit follows the lock state
// - erase reset in response of abandoning command
// - idle after reset, ready after init done
// - response-type bits evaluated for this response
// - execution bits captured, fetched by later response
// - spi mode hides only relative card address
// - class code 01h, 08h, 02h
// - lock aborts every media-touching nvme command
// - admin aborts return operation denied
// - io aborts return access denied
// - legacy write protect aborts nvme writes
// - protection enforced on both interfaces alike, except upc aborts nvme writes only with the wp feature set
// - permanent/power-cycle changes need block authentication in nvme mode
// - protected area and its commands denied over pcie
// - nvme capacity equals legacy user area size
// - error bits clear when read in the long format only
`timescale 1ns/1ns
module card_status_guard (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // register bus, write channels
  input  wire logic [7:0]              awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // register bus, read channels
  input  wire logic [7:0]              araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // legacy card side: events and status responses
  input  wire guard_pkg::card_event_t  card_event,
  input  wire logic                    resp_req,
  input  wire logic                    resp_long,
  output guard_pkg::status_resp_t      status_resp,
  output logic                         resp_valid,
  // legacy register read selector
  input  wire logic                    reg_sel_req,
  input  wire logic [2:0]              reg_sel,
  output logic                         reg_sel_valid,
  output logic                         reg_sel_ok,
  // nvme side
  input  wire guard_pkg::nvme_cmd_t    nvme_cmd,
  output guard_pkg::verdict_t          verdict,
  // shared state views
  output logic                         legacy_write_block,
  output logic [23:0]                  class_code,
  output logic [31:0]                  nvme_capacity
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus slave
  logic                     aw_hold_reg;
  logic [7:0]               aw_addr_reg;
  logic                     w_hold_reg;
  logic [31:0]              w_data_reg;
  logic [3:0]               w_strb_reg;
  logic                     bvalid_reg;
  logic [1:0]               bresp_reg;
  logic                     rvalid_reg;
  logic [31:0]              rdata_reg;
  logic [1:0]               rresp_reg;

  logic [3:0]               ctrl_reg;
  guard_pkg::protect_t      prot_reg;
  guard_pkg::protect_t      prot_next;
  logic [31:0]              user_size_reg;

  logic                     overwrite_reg;
  logic                     skip_reg;
  logic                     lockfail_reg;
  logic                     erase_reset_reg;
  logic                     idle_reg;
  guard_pkg::status_resp_t  status_resp_reg;
  logic                     resp_valid_reg;
  logic                     reg_sel_valid_reg;
  logic                     reg_sel_ok_reg;

  logic                     do_write;
  logic                     do_read;
  logic                     wr_ctrl;
  logic                     wr_prot;
  logic                     wr_size;
  logic                     wr_mapped;
  logic [31:0]              wr_word;
  logic [31:0]              ctrl_word;
  logic [31:0]              prot_word;
  logic [31:0]              status_word;
  logic [31:0]              rd_word;
  logic                     rd_mapped;

  assign awready  = !aw_hold_reg;
  assign wready   = !w_hold_reg;
  // both halves held, answer only once the previous response left
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign do_read  = arvalid && !rvalid_reg;
  assign arready  = !rvalid_reg;

  assign wr_ctrl   = do_write && aw_addr_reg == guard_pkg::OFF_CTRL;
  assign wr_prot   = do_write && aw_addr_reg == guard_pkg::OFF_PROTECT;
  assign wr_size   = do_write && aw_addr_reg == guard_pkg::OFF_USER_SIZE;
  assign wr_mapped = wr_ctrl || wr_prot || wr_size;

  assign ctrl_word = {28'h0000000, ctrl_reg};
  assign prot_word = {28'h0000000, prot_reg};
  assign wr_word   = apply_strb(wr_ctrl ? ctrl_word :
                                wr_prot ? prot_word : user_size_reg,
                                w_data_reg, w_strb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (awvalid && awready) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (wvalid && wready) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= guard_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_mapped ? guard_pkg::RESP_OKAY :
                                guard_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp  = bresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // control and shared protection state, one copy for both sides
  logic auth_ok;
  logic pwp_reverse;

  // in nvme mode the permanent and power-cycle bits move only after auth
  assign auth_ok = !ctrl_reg[guard_pkg::CTRL_NVME_MODE] ||
                   ctrl_reg[guard_pkg::CTRL_AUTH];
  assign prot_next.locked = wr_prot ? wr_word[guard_pkg::PROT_LOCK] :
                                      prot_reg.locked;
  assign prot_next.temporary_write_protect    = wr_prot ? wr_word[guard_pkg::PROT_TWP] :
                                      prot_reg.temporary_write_protect;
  // permanent and power-cycle bits never clear short of a reset
  assign prot_next.permanent_write_protect = prot_reg.permanent_write_protect ||
         (wr_prot && wr_word[guard_pkg::PROT_PWP] && auth_ok);
  assign prot_next.upc = prot_reg.upc ||
         (wr_prot && wr_word[guard_pkg::PROT_UPC] && auth_ok);
  assign pwp_reverse = wr_prot && prot_reg.permanent_write_protect &&
                       !wr_word[guard_pkg::PROT_PWP];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg      <= guard_pkg::CTRL_RST;
      prot_reg      <= '0;
      user_size_reg <= guard_pkg::USER_SIZE_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= wr_word[3:0];
      prot_reg <= prot_next;
      if (wr_size) user_size_reg <= wr_word;
    end
  end

  assign legacy_write_block = prot_reg.temporary_write_protect | prot_reg.permanent_write_protect |
                              prot_reg.upc;
  assign class_code    = guard_pkg::CLASS_CODE;
  assign nvme_capacity = user_size_reg;

  ////////////////////////////////////////////////////////////////////////////
  // error bits: set wins over the read clear; erase reset register clears instead
  logic clr_any;
  logic clr_long;
  logic erase_reset_now;
  logic overwrite_set;

  assign clr_any  = resp_req;
  assign clr_long = resp_req && resp_long;
  assign overwrite_set = card_event.csd_mismatch ||
                         card_event.csd_reverse || pwp_reverse;
  // response-type bit: the abandoning command carries it itself
  assign erase_reset_now = erase_reset_reg ||
                           card_event.erase_abandon;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overwrite_reg   <= 1'b0;
      skip_reg        <= 1'b0;
      lockfail_reg    <= 1'b0;
      erase_reset_reg <= 1'b0;
    end else begin
      overwrite_reg <= overwrite_set || (overwrite_reg && !clr_long);
      skip_reg      <= card_event.erase_partial ||
                       (skip_reg && !clr_long);
      lockfail_reg  <= card_event.lock_error ||
                       (lockfail_reg && !clr_long);
      erase_reset_reg <= erase_reset_now && !clr_any;
    end
  end

  // reset command wins over a coincident init completion
  always_ff @(posedge aclk) begin
    if (!aresetn)                  idle_reg <= 1'b1;
    else if (card_event.reset_cmd) idle_reg <= 1'b1;
    else if (card_event.init_done) idle_reg <= 1'b0;
  end

  guard_pkg::status_resp_t resp_next;
  always_comb begin
    resp_next = '0;
    resp_next.short_byte[guard_pkg::R1_IDLE]        = idle_reg;
    resp_next.short_byte[guard_pkg::R1_ERASE_RESET] = erase_reset_now;
    if (resp_long) begin
      resp_next.long_byte[guard_pkg::R2_LOCKED]    = prot_reg.locked;
      resp_next.long_byte[guard_pkg::R2_SKIP_FAIL] = skip_reg |
                                                      lockfail_reg;
      resp_next.long_byte[guard_pkg::R2_OVERWRITE] = overwrite_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_resp_reg <= '0;
      resp_valid_reg  <= 1'b0;
    end else begin
      resp_valid_reg <= resp_req;
      if (resp_req) status_resp_reg <= resp_next;
    end
  end

  assign status_resp = status_resp_reg;
  assign resp_valid  = resp_valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // legacy register selector: only the address register is hidden
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_sel_valid_reg <= 1'b0;
      reg_sel_ok_reg    <= 1'b0;
    end else begin
      reg_sel_valid_reg <= reg_sel_req;
      reg_sel_ok_reg <= !(ctrl_reg[guard_pkg::CTRL_SPI_MODE] &&
                          reg_sel == guard_pkg::SEL_RCA);
    end
  end

  assign reg_sel_valid = reg_sel_valid_reg;
  assign reg_sel_ok    = reg_sel_ok_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register read path; a bus read does not clear the card status bits
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[guard_pkg::ST_OVERWRITE]   = overwrite_reg;
    status_word[guard_pkg::ST_ERASE_SKIP]  = skip_reg;
    status_word[guard_pkg::ST_LOCK_FAIL]   = lockfail_reg;
    status_word[guard_pkg::ST_LOCKED]      = prot_reg.locked;
    status_word[guard_pkg::ST_ERASE_RESET] = erase_reset_reg;
    status_word[guard_pkg::ST_IDLE]        = idle_reg;
    status_word[guard_pkg::ST_PROT_LSB +: 4] = prot_reg;
  end

  assign rd_mapped = araddr == guard_pkg::OFF_CTRL ||
                     araddr == guard_pkg::OFF_STATUS ||
                     araddr == guard_pkg::OFF_PROTECT ||
                     araddr == guard_pkg::OFF_USER_SIZE ||
                     araddr == guard_pkg::OFF_CLASS;
  assign rd_word =
    araddr == guard_pkg::OFF_CTRL      ? ctrl_word :
    araddr == guard_pkg::OFF_STATUS    ? status_word :
    araddr == guard_pkg::OFF_PROTECT   ? prot_word :
    araddr == guard_pkg::OFF_USER_SIZE ? user_size_reg :
    araddr == guard_pkg::OFF_CLASS     ? {8'h00, guard_pkg::CLASS_CODE} :
                                         32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= guard_pkg::RESP_OKAY;
    end else if (do_read) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_mapped ? guard_pkg::RESP_OKAY :
                                guard_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign rvalid = rvalid_reg;
  assign rdata  = rdata_reg;
  assign rresp  = rresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  nvme_gate u_gate (
    .aclk    (aclk),
    .aresetn (aresetn),
    .prot    (prot_reg),
    .wp_feat (ctrl_reg[guard_pkg::CTRL_WP_FEAT]),
    .cmd     (nvme_cmd),
    .verdict (verdict)
  );

  ////////////////////////////////////////////////////////////////////////////
  chk_idle_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    card_event.init_done && !card_event.reset_cmd ##1 resp_req
    |=> resp_valid && !status_resp.short_byte[guard_pkg::R1_IDLE])
    else $error("idle bit still set after init done");

  chk_skip_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    resp_req && resp_long && !card_event.erase_partial &&
    !card_event.lock_error ##1 resp_req && resp_long
    |=> !status_resp.long_byte[guard_pkg::R2_SKIP_FAIL])
    else $error("erase skip not cleared by read");

  chk_lockfail_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    card_event.lock_error && clr_long ##1 resp_req && resp_long
    |=> status_resp.long_byte[guard_pkg::R2_SKIP_FAIL])
    else $error("lock failure lost against clear");

  chk_locked_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    resp_req && resp_long
    |=> status_resp.long_byte[guard_pkg::R2_LOCKED] == $past(prot_reg.locked))
    else $error("locked bit does not follow state");

  chk_erase_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    resp_req && card_event.erase_abandon
    |=> status_resp.short_byte[guard_pkg::R1_ERASE_RESET]
        ##1 !erase_reset_reg || $past(card_event.erase_abandon))
    else $error("erase reset missing from its response");

  chk_pwp_auth: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_prot && !auth_ok && !prot_reg.permanent_write_protect |=> !prot_reg.permanent_write_protect)
    else $error("permanent protect set without auth");

  chk_rca_hidden: assert property (@(posedge aclk) disable iff (!aresetn)
    reg_sel_req && ctrl_reg[guard_pkg::CTRL_SPI_MODE] &&
    reg_sel == guard_pkg::SEL_RCA |=> reg_sel_valid && !reg_sel_ok)
    else $error("address register visible in spi mode");

  chk_capacity_eq: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_size |=> nvme_capacity == $past(wr_word))
    else $error("nvme capacity differs from user size");

  chk_overwrite_rev: assert property (@(posedge aclk) disable iff (!aresetn)
    pwp_reverse ##1 resp_req && resp_long
    |=> status_resp.long_byte[guard_pkg::R2_OVERWRITE] && prot_reg.permanent_write_protect)
    else $error("protect reversal not flagged");

endmodule

// ==== design/guard_pkg.sv ====
// constants and carrier types for the card status and access guard
// assumes one clock domain; all users reference names as guard_pkg::name
package guard_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the 32-bit register bus
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_PROTECT   = 8'h08;
  localparam logic [7:0] OFF_USER_SIZE = 8'h0c;
  localparam logic [7:0] OFF_CLASS     = 8'h10;

  // control register fields
  localparam int CTRL_SPI_MODE  = 0;
  localparam int CTRL_NVME_MODE = 1;
  localparam int CTRL_WP_FEAT   = 2;
  localparam int CTRL_AUTH      = 3;
  localparam int CTRL_W         = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // protect register fields
  localparam int PROT_LOCK = 0;
  localparam int PROT_TWP  = 1;
  localparam int PROT_PWP  = 2;
  localparam int PROT_UPC  = 3;

  // status register fields
  localparam int ST_OVERWRITE   = 0;
  localparam int ST_ERASE_SKIP  = 1;
  localparam int ST_LOCK_FAIL   = 2;
  localparam int ST_LOCKED      = 3;
  localparam int ST_ERASE_RESET = 4;
  localparam int ST_IDLE        = 5;
  localparam int ST_PROT_LSB    = 8;

  localparam logic [31:0] USER_SIZE_RST = 32'h0000_0000;

  // short and long status response bit positions
  localparam int R1_IDLE        = 0;
  localparam int R1_ERASE_RESET = 1;
  localparam int R2_LOCKED      = 0;
  localparam int R2_SKIP_FAIL   = 1;
  localparam int R2_OVERWRITE   = 7;

  // identification class: base, sub, programming interface
  localparam logic [23:0] CLASS_CODE = 24'h01_08_02;

  // command abort status codes
  localparam logic [7:0] SC_OK         = 8'h00;
  localparam logic [7:0] SC_OP_DENIED  = 8'h01;
  localparam logic [7:0] SC_ACC_DENIED = 8'h02;

  // register selector code of the relative card address
  localparam logic [2:0] SEL_RCA = 3'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic csd_mismatch;
    logic csd_reverse;
    logic erase_partial;
    logic lock_error;
    logic erase_abandon;
    logic reset_cmd;
    logic init_done;
  } card_event_t;

  typedef struct packed {
    logic valid;
    logic admin;
    logic reads;
    logic writes;
    logic cpa;
    logic content_protection_scheme;
  } nvme_cmd_t;

  typedef struct packed {
    logic upc;
    logic permanent_write_protect;
    logic temporary_write_protect;
    logic locked;
  } protect_t;

  typedef struct packed {
    logic       valid;
    logic       deny;
    logic [7:0] code;
  } verdict_t;

  typedef struct packed {
    logic [7:0] short_byte;
    logic [7:0] long_byte;
  } status_resp_t;

endpackage

// ==== design/nvme_gate.sv ====
// nvme command gate: one registered verdict per command
// assumes command and protection state come from the aclk domain
`timescale 1ns/1ns
module nvme_gate (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // shared protection state and feature option
  input  wire guard_pkg::protect_t  prot,
  input  wire logic                 wp_feat,
  // command in, verdict out
  input  wire guard_pkg::nvme_cmd_t cmd,
  output guard_pkg::verdict_t       verdict
);

  guard_pkg::verdict_t verdict_reg;
  guard_pkg::verdict_t verdict_next;
  logic                media;
  logic                lock_hit;
  logic                wp_on;
  logic                wp_hit;
  logic                deny;

  assign media    = cmd.reads | cmd.writes;
  assign lock_hit = prot.locked & media;
  // until-power-cycle only exists where the nvme protect features do
  assign wp_on    = prot.temporary_write_protect | prot.permanent_write_protect | (wp_feat & prot.upc);
  assign wp_hit   = wp_on & cmd.writes;
  // protected area and its commands are never reachable from this side
  assign deny     = lock_hit | wp_hit | cmd.cpa | cmd.content_protection_scheme;

  assign verdict_next.valid = cmd.valid;
  assign verdict_next.deny  = cmd.valid & deny;
  assign verdict_next.code  = !deny ? guard_pkg::SC_OK :
                              cmd.admin ? guard_pkg::SC_OP_DENIED :
                              guard_pkg::SC_ACC_DENIED;

  always_ff @(posedge aclk) begin
    if (!aresetn) verdict_reg <= '0;
    else          verdict_reg <= verdict_next;
  end

  assign verdict = verdict_reg;

  ////////////////////////////////////////////////////////////////////////////
  chk_lock_abort: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd.valid && prot.locked && (cmd.reads || cmd.writes)
    |=> verdict.valid && verdict.deny)
    else $error("locked media command not aborted");

  chk_admin_code: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd.valid && cmd.admin && prot.locked && cmd.reads
    |=> verdict.code == guard_pkg::SC_OP_DENIED)
    else $error("admin abort has wrong status code");

  chk_io_code: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd.valid && !cmd.admin && prot.locked && cmd.writes
    |=> verdict.code == guard_pkg::SC_ACC_DENIED)
    else $error("io abort has wrong status code");

  chk_wp_write: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd.valid && cmd.writes && (prot.temporary_write_protect || prot.permanent_write_protect)
    |=> verdict.deny)
    else $error("write under protection not aborted");

  chk_cpa_denied: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd.valid && (cmd.cpa || cmd.content_protection_scheme) |=> verdict.deny)
    else $error("protected area access not denied");

  chk_clean_pass: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd.valid && !cmd.cpa && !cmd.content_protection_scheme && !cmd.writes && !prot.locked
    |=> !verdict.deny && verdict.code == guard_pkg::SC_OK)
    else $error("harmless command was aborted");

endmodule
